//--- inc/gpe_pkg.sv
package gpe_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFF_OUT = 3'h0;
    localparam logic [2:0] OFF_IN = 3'h1;
    localparam logic [2:0] OFF_EN = 3'h2;
    localparam logic [2:0] OFF_ST = 3'h3;
    localparam logic [2:0] OFF_SEL = 3'h4;
    localparam logic [2:0] OFF_CFG = 3'h5;
    localparam logic [2:0] OFF_RTE = 3'h6;
    localparam int NPIN = 8;
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CB_OE = 0;
    localparam int CB_PP = 1;
    localparam int CB_PU = 2;
    localparam int CB_LK = 3;
    localparam int CB_TY = 4;
    localparam int CB_PO = 5;
    localparam int CB_DB = 6;
    localparam logic [7:0] CFG_RST = 8'h44;
    localparam logic [7:0] CFG_WMASK = 8'h7F;
    localparam logic [7:0] CFG_LOW4 = 8'h0F;
    localparam logic [7:0] CFG_EVT = 8'h70;
    localparam logic [7:0] RTE_RST = 8'h01;
    localparam logic [7:0] RTE_MASK = 8'h03;
    localparam logic [7:0] OUT_RST = 8'hFF;
    localparam logic [7:0] ZERO8 = 8'h00;
    // Idle pin level: pull-ups are on after reset
    localparam logic [7:0] PIN_IDLE = 8'hFF;
    localparam int RB_IRQ = 0;
    localparam int RB_SMI = 1;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int DEB_MS = 15;
    localparam int DEB_CYC = CLK_HZ / 1000 * DEB_MS;
    localparam int DEB_W = 20;
    // ****************************************
    // Carrier
    // ****************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gpe_bus_s;
    typedef struct packed {
        logic [NPIN-1:0] o;
        logic [NPIN-1:0] oe;
        logic [NPIN-1:0] pu;
    } gpe_pins_s;
endpackage : gpe_pkg

//--- rtl/gpe_port.sv
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
module gpe_port #(
    parameter bit ENHANCED = 1'b1,
    parameter int DEB_COUNT = gpe_pkg::DEB_CYC
) (
    input wire logic i_clk,                     // 20 MHz clock
    input wire logic i_rstn,                    // Sync reset, low
    input wire gpe_pkg::gpe_bus_s i_bus,        // Register request
    output logic [7:0] o_rdata,                 // Read data, next cycle
    input wire logic i_active,                  // Port activation
    input wire logic [gpe_pkg::NPIN-1:0] i_pin, // Pin levels
    output gpe_pkg::gpe_pins_s o_pins,          // Pin drive
    output logic o_irq,                         // Interrupt request
    output logic o_smi                          // System mgmt interrupt
);
    import gpe_pkg::*;

    logic [7:0] cfg [NPIN];
    logic [7:0] rte [NPIN];
    logic [7:0] dout;
    logic [7:0] en;
    logic [7:0] st;
    logic [2:0] sel;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] deb;
    logic [7:0] prev;
    logic [DEB_W-1:0] cnt [NPIN];
    logic [7:0] hit;
    logic [7:0] evmask;

    function automatic logic wr_at(input gpe_bus_s b, input logic [2:0] a);
        wr_at = b.wr && (b.addr == a);
    endfunction : wr_at

    assign evmask = ENHANCED ? CFG_WMASK : (CFG_WMASK & ~CFG_EVT);

    // ****************************************
    // Pin index and configuration
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sel <= 3'h0;
        end else if (wr_at(i_bus, OFF_SEL)) begin
            sel <= i_bus.wdata[2:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            for (int i = 0; i < NPIN; i++) begin
                cfg[i] <= CFG_RST & evmask;
                rte[i] <= ENHANCED ? RTE_RST : ZERO8;
            end
        end else begin
            if (wr_at(i_bus, OFF_CFG)) begin
                if (cfg[sel][CB_LK]) begin
                    // Only event bits stay writable once locked
                    cfg[sel] <= (cfg[sel] & ~CFG_EVT)
                        | (i_bus.wdata & CFG_EVT & evmask);
                end else begin
                    // Lock ORs in: software never clears it
                    cfg[sel] <= (i_bus.wdata & evmask)
                        | (cfg[sel] & (8'h01 << CB_LK));
                end
            end
            if (wr_at(i_bus, OFF_RTE) && ENHANCED) begin
                rte[sel] <= i_bus.wdata & RTE_MASK;
            end
        end
    end

    // ****************************************
    // Runtime registers
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            dout <= OUT_RST;
        end else if (wr_at(i_bus, OFF_OUT) && i_active) begin
            for (int i = 0; i < NPIN; i++) begin
                if (!cfg[i][CB_LK]) begin
                    dout[i] <= i_bus.wdata[i];
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            en <= ZERO8;
        end else if (wr_at(i_bus, OFF_EN) && ENHANCED) begin
            en <= i_bus.wdata;
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st <= ZERO8;
        end else begin
            st <= (st & ~(wr_at(i_bus, OFF_ST) ? i_bus.wdata : ZERO8))
                | hit;
        end
    end

    // ****************************************
    // Input path
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            s1 <= PIN_IDLE;
            s2 <= PIN_IDLE;
        end else begin
            s1 <= i_pin;
            s2 <= s1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            deb <= PIN_IDLE;
            for (int i = 0; i < NPIN; i++) begin
                cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                if (!i_active) begin
                    cnt[i] <= '0;
                end else if (!cfg[i][CB_DB] || s2[i] == deb[i]) begin
                    deb[i] <= s2[i];
                    cnt[i] <= '0;
                end else if (cnt[i] == DEB_W'(DEB_COUNT - 1)) begin
                    deb[i] <= s2[i];
                    cnt[i] <= '0;
                end else begin
                    cnt[i] <= cnt[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            prev <= PIN_IDLE;
        end else begin
            prev <= deb;
        end
    end

    always_comb begin
        hit = ZERO8;
        for (int i = 0; i < NPIN; i++) begin
            if (ENHANCED && i_active) begin
                if (cfg[i][CB_TY]) begin
                    hit[i] = deb[i] == cfg[i][CB_PO];
                end else begin
                    hit[i] = (deb[i] != prev[i])
                        && (deb[i] == cfg[i][CB_PO]);
                end
            end
        end
    end

    // ****************************************
    // Notification
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
            o_smi <= 1'b0;
        end else begin
            o_irq <= 1'b0;
            o_smi <= 1'b0;
            for (int i = 0; i < NPIN; i++) begin
                if (st[i] && en[i] && rte[i][RB_IRQ]) begin
                    o_irq <= 1'b1;
                end
                if (st[i] && en[i] && rte[i][RB_SMI]) begin
                    o_smi <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_pins <= '0;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                // Open-drain drives only the low level
                o_pins.oe[i] <= cfg[i][CB_OE]
                    && (cfg[i][CB_PP] || !dout[i]);
                o_pins.o[i] <= dout[i];
                o_pins.pu[i] <= cfg[i][CB_PU];
            end
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_rdata <= ZERO8;
        end else if (i_bus.rd) begin
            case (i_bus.addr)
                OFF_OUT: o_rdata <= i_active ? dout : ZERO8;
                OFF_IN: o_rdata <= i_active ? s2 : ZERO8;
                OFF_EN: o_rdata <= en;
                OFF_ST: o_rdata <= st;
                OFF_SEL: o_rdata <= {5'h00, sel};
                OFF_CFG: o_rdata <= cfg[sel];
                OFF_RTE: o_rdata <= rte[sel];
                default: o_rdata <= ZERO8;
            endcase
        end else begin
            o_rdata <= ZERO8;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb_chk @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    AST_LOCK_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cfg[sel][CB_LK] |=> cfg[$past(sel)][CB_LK])
        else $error("lock cleared");
    AST_LOCK_CFG: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cfg[sel][CB_LK] && wr_at(i_bus, OFF_CFG)
        |=> (cfg[$past(sel)] & CFG_LOW4) == $past(cfg[sel] & CFG_LOW4))
        else $error("locked cfg changed");
    AST_DOUT_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_bus.rd && i_bus.addr == OFF_OUT && i_active
        |=> o_rdata == $past(dout))
        else $error("data-out readback wrong");
    AST_DIN_RO: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_at(i_bus, OFF_IN) |=> $stable(dout) && $stable(en))
        else $error("data-in write had effect");
    AST_INACT_OUT: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !i_active |=> $stable(dout))
        else $error("inactive port changed data-out");
    AST_ST_SET: assert property (@(posedge i_clk) disable iff (!i_rstn)
        hit != ZERO8 |=> (st & $past(hit)) == $past(hit))
        else $error("event lost");
    AST_IRQ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (en == ZERO8) ##1 (en == ZERO8) |-> !o_irq && !o_smi)
        else $error("notify without enable");
    AST_DRIVE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !cfg[0][CB_OE] |=> !o_pins.oe[0])
        else $error("pin driven while disabled");
    AST_LEVEL: assert property (@(posedge i_clk) disable iff (!i_rstn)
        ENHANCED && i_active && cfg[0][CB_TY]
        && deb[0] == cfg[0][CB_PO] |=> st[0])
        else $error("level event missed");

    // Register access
    AST_SEL_WR: assert property (
        wr_at(i_bus, OFF_SEL) |=> sel == $past(i_bus.wdata[2:0]))
        else $error("select write lost");
    AST_CFG_RD: assert property (
        i_bus.rd && i_bus.addr == OFF_CFG |=> o_rdata == $past(cfg[sel]))
        else $error("configuration readback wrong");
    AST_RTE_RD: assert property (
        i_bus.rd && i_bus.addr == OFF_RTE |=> o_rdata == $past(rte[sel]))
        else $error("routing readback wrong");
    AST_RTE_RSV: assert property (
        (rte[sel] & ~RTE_MASK) == ZERO8)
        else $error("reserved routing bits set");
    AST_CFG_B7: assert property (
        cfg[sel][7] == 1'b0)
        else $error("reserved configuration bit set");
    AST_BASIC: assert property (
        !ENHANCED |-> (cfg[sel] & CFG_EVT) == ZERO8)
        else $error("event bits set in basic port");
    AST_DIN_READ: assert property (
        i_bus.rd && i_bus.addr == OFF_IN && i_active
        |=> o_rdata == $past(s2))
        else $error("data-in readback wrong");
    AST_INACT_RD: assert property (
        i_bus.rd && !i_active
        && (i_bus.addr == OFF_IN || i_bus.addr == OFF_OUT)
        |=> o_rdata == ZERO8)
        else $error("inactive port data readable");
    AST_IDLE_RD: assert property (
        !i_bus.rd |=> o_rdata == ZERO8)
        else $error("read data outside read cycle");
    AST_DOUT_WR: assert property (
        wr_at(i_bus, OFF_OUT) && i_active && !cfg[0][CB_LK]
        |=> dout[0] == $past(i_bus.wdata[0]))
        else $error("data-out write lost");
    AST_DOUT_LOCK: assert property (
        wr_at(i_bus, OFF_OUT) && cfg[2][CB_LK] |=> $stable(dout[2]))
        else $error("locked data-out changed");
    AST_CFG_WR: assert property (
        wr_at(i_bus, OFF_CFG) && !cfg[sel][CB_LK]
        |=> cfg[$past(sel)] == ($past(i_bus.wdata) & evmask))
        else $error("configuration write lost");
    AST_LOCK_SET: assert property (
        wr_at(i_bus, OFF_CFG) && i_bus.wdata[CB_LK]
        |=> cfg[$past(sel)][CB_LK])
        else $error("lock not set");
    AST_RTE_WR: assert property (
        wr_at(i_bus, OFF_RTE) && ENHANCED
        |=> rte[$past(sel)] == ($past(i_bus.wdata) & RTE_MASK))
        else $error("routing write lost");
    AST_EN_WR: assert property (
        wr_at(i_bus, OFF_EN) && ENHANCED |=> en == $past(i_bus.wdata))
        else $error("enable write lost");

    // Pin drive
    AST_PIN_O: assert property (
        1'b1 |=> o_pins.o == $past(dout))
        else $error("pin value differs from data-out");
    AST_PIN_PU: assert property (
        1'b1 |=> o_pins.pu[3] == $past(cfg[3][CB_PU]))
        else $error("pull-up differs from configuration");
    AST_PP_DRIVE: assert property (
        cfg[2][CB_OE] && cfg[2][CB_PP] |=> o_pins.oe[2])
        else $error("push-pull pin not driven");
    AST_OD_HIGH: assert property (
        !cfg[5][CB_PP] && dout[5] |=> !o_pins.oe[5])
        else $error("open-drain pin drives high");
    AST_OE_LOW: assert property (
        cfg[5][CB_OE] && !dout[5] |=> o_pins.oe[5])
        else $error("enabled pin not driven low");

    // Input path and events
    AST_SYNC: assert property (
        1'b1 |=> s1 == $past(i_pin) && s2 == $past(s1))
        else $error("synchroniser stage skipped");
    AST_DEB_OFF: assert property (
        i_active && !cfg[3][CB_DB] |=> deb[3] == $past(s2[3]))
        else $error("undebounced input delayed");
    AST_DEB_HOLD: assert property (
        cfg[3][CB_DB] && s2[3] != deb[3]
        && cnt[3] != DEB_W'(DEB_COUNT - 1) |=> $stable(deb[3]))
        else $error("debounce passed input early");
    AST_EDGE: assert property (
        ENHANCED && i_active && !cfg[3][CB_TY] && !cfg[3][CB_PO]
        && prev[3] && !deb[3] |=> st[3])
        else $error("falling edge missed");
    AST_NO_EDGE: assert property (
        !cfg[3][CB_TY] && deb[3] == prev[3] |-> !hit[3])
        else $error("edge event without transition");
    AST_INACT_HIT: assert property (
        !i_active |-> hit == ZERO8)
        else $error("event on inactive port");
    AST_W1C: assert property (
        wr_at(i_bus, OFF_ST) && hit == ZERO8
        |=> (st & $past(i_bus.wdata)) == ZERO8)
        else $error("status not cleared");
    AST_ST_KEEP: assert property (
        !wr_at(i_bus, OFF_ST) |=> (st & $past(st)) == $past(st))
        else $error("status dropped without clear");

    // Notification
    AST_IRQ_SET: assert property (
        st[3] && en[3] && rte[3][RB_IRQ] |=> o_irq)
        else $error("interrupt request missing");
    AST_SMI_SET: assert property (
        st[3] && en[3] && rte[3][RB_SMI] |=> o_smi)
        else $error("management interrupt missing");
endmodule : gpe_port

//--- tb/gpe_pins_model.sv
`timescale 1ns/1ns
// ****************************************
// External devices and wiring on the eight pins
// ****************************************
module gpe_pins_model (
    input wire logic i_clk,                 // Bench clock
    input wire gpe_pkg::gpe_pins_s i_pins,  // Port drive
    input wire logic [7:0] i_ext_en,        // External drive on
    input wire logic [7:0] i_ext_val,       // External level
    output logic [7:0] o_pin                // Resolved pin level
);
    import gpe_pkg::*;
    logic [7:0] float_val = 8'h00;
    // A pin nobody drives or pulls changes every cycle
    always @(posedge i_clk) begin
        float_val <= ~float_val;
    end
    always_comb begin
        for (int n = 0; n < NPIN; n++) begin
            o_pin[n] = i_pins.oe[n] ? i_pins.o[n] : i_ext_en[n] ?
                i_ext_val[n] : i_pins.pu[n] ? 1'b1 : float_val[n];
        end
    end
endmodule : gpe_pins_model

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import gpe_pkg::*;
    localparam int DEB = 8;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_active = 1'b1;
    gpe_bus_s bus = '0;
    logic [7:0] o_rdata;
    gpe_pins_s pins;
    logic [7:0] pin;
    logic o_irq;
    logic o_smi;
    logic [7:0] ext_en = 8'hFF;
    logic [7:0] ext_val = 8'hFF;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic [7:0] r;
    int fails = 0;
    int n_checks = 0;

    gpe_port #(.ENHANCED(1'b1), .DEB_COUNT(DEB)) u_dut (.i_clk(i_clk),
        .i_rstn(i_rstn), .i_bus(bus), .o_rdata(o_rdata),
        .i_active(i_active), .i_pin(pin), .o_pins(pins), .o_irq(o_irq),
        .o_smi(o_smi));
    gpe_pins_model u_pins (.i_clk(i_clk), .i_pins(pins), .i_ext_en(ext_en),
        .i_ext_val(ext_val), .o_pin(pin));

    initial begin
        forever #25 i_clk = ~i_clk;
    end
    // ****************************************
    // Checks, bus cycles, scoreboard
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        bus.wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        bus.rd <= 1'b0;
    endtask : bus_rd
    task automatic wait_note(input logic [1:0] want);
        int i;
        for (i = 0; i < 100 && {o_irq, o_smi} !== want; i++) begin
            @(negedge i_clk);
        end
        chk({6'h00, o_irq, o_smi}, {6'h00, want});
        if (i == 100) begin
            end_of_test();
        end
    endtask : wait_note
    task automatic reset_dut();
        i_rstn <= 1'b0;
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
    endtask : reset_dut
    // Read data stand in the cycle after the strobe
    always @(posedge i_clk) begin
        rd_seen <= bus.rd;
    end
    always @(negedge i_clk) begin
        if (rd_seen) begin
            chk(o_rdata, exp_q.pop_front());
        end
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        r = 8'($urandom(56));
        reset_dut();
        bus_rd(OFF_CFG, 8'h44);
        bus_rd(OFF_RTE, 8'h01);
        bus_rd(OFF_OUT, 8'hFF);
        bus_rd(OFF_EN, 8'h00);
        bus_rd(OFF_ST, 8'h00);
        bus_rd(3'h7, 8'h00);
        @(negedge i_clk);
        chk(pins.oe, 8'h00);
        chk(pins.pu, 8'hFF);
        @(posedge i_clk) ext_val <= r;
        repeat (4) @(posedge i_clk);
        bus_wr(OFF_IN, ~r);
        bus_rd(OFF_IN, r);
        // Pin 2 push-pull, pin 5 open-drain, others driven outside
        @(posedge i_clk) ext_en <= 8'hDB;
        ext_val <= ~r;
        bus_wr(OFF_SEL, 8'h02);
        bus_wr(OFF_CFG, 8'h07);
        bus_wr(OFF_SEL, 8'h05);
        bus_wr(OFF_CFG, 8'h05);
        bus_wr(OFF_OUT, r);
        repeat (4) @(posedge i_clk);
        bus_rd(OFF_IN, (~r & 8'hDB) | (r & 8'h24));
        @(negedge i_clk);
        chk(pins.oe & 8'h24, {2'b00, ~r[5], 2'b00, 1'b1, 2'b00});
        chk(pins.o & 8'h04, r & 8'h04);
        bus_wr(OFF_SEL, 8'h02);
        bus_wr(OFF_CFG, 8'h0F);
        bus_wr(OFF_CFG, 8'h00);
        bus_rd(OFF_CFG, 8'h0F);
        bus_wr(OFF_OUT, ~r);
        bus_rd(OFF_OUT, (~r & 8'hFB) | (r & 8'h04));
        @(posedge i_clk) i_active <= 1'b0;
        bus_wr(OFF_OUT, r);
        bus_rd(OFF_OUT, 8'h00);
        bus_rd(OFF_IN, 8'h00);
        @(negedge i_clk);
        chk(pins.oe & 8'h20, {2'b00, r[5], 5'b00000});
        @(posedge i_clk) i_active <= 1'b1;
        bus_rd(OFF_OUT, (~r & 8'hFB) | (r & 8'h04));
        // Events on pin 3: debounced falling edge
        @(posedge i_clk) ext_en <= 8'hFF;
        ext_val <= 8'hFF;
        repeat (20) @(posedge i_clk);
        bus_wr(OFF_ST, 8'hFF);
        bus_rd(OFF_ST, 8'h00);
        @(posedge i_clk) ext_val <= 8'hF7;
        repeat (3) @(posedge i_clk);
        ext_val <= 8'hFF;
        repeat (20) @(posedge i_clk);
        bus_rd(OFF_ST, 8'h00);
        @(posedge i_clk) ext_val <= 8'hF7;
        repeat (6) @(posedge i_clk);
        bus_rd(OFF_ST, 8'h00);
        repeat (10) @(posedge i_clk);
        bus_rd(OFF_ST, 8'h08);
        chk({7'h00, o_irq}, 8'h00);
        bus_wr(OFF_EN, 8'h08);
        wait_note(2'b10);
        bus_wr(OFF_SEL, 8'h03);
        bus_wr(OFF_RTE, 8'hFE);
        wait_note(2'b01);
        bus_rd(OFF_RTE, 8'h02);
        bus_wr(OFF_RTE, 8'h03);
        wait_note(2'b11);
        bus_wr(OFF_ST, 8'h08);
        wait_note(2'b00);
        // Pin 4 high level, debounce off for prompt release
        bus_wr(OFF_SEL, 8'h04);
        bus_wr(OFF_CFG, 8'h34);
        repeat (4) @(posedge i_clk);
        bus_wr(OFF_ST, 8'h10);
        bus_rd(OFF_ST, 8'h10);
        @(posedge i_clk) ext_val <= 8'hE7;
        repeat (4) @(posedge i_clk);
        bus_wr(OFF_ST, 8'h10);
        bus_rd(OFF_ST, 8'h00);
        reset_dut();
        bus_wr(OFF_SEL, 8'h02);
        bus_rd(OFF_CFG, 8'h44);
        repeat (2) @(posedge i_clk);
        end_of_test();
    end
endmodule : tb_top
